// ===== hw/mbm_mapper.sv
// modbus function decoder and coil/register mapper over the i/o buffer
`timescale 1ns/100ps
module mbm_mapper (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_strict_mode,
	input wire mbm_pkg::mbm_req_t i_req,
	output logic o_req_ready,
	input wire mbm_pkg::mbm_word_t i_wr,
	output logic o_wr_ready,
	output mbm_pkg::mbm_word_t o_rd,
	input wire logic i_rd_ready,
	output mbm_pkg::mbm_rsp_t o_rsp,
	input wire logic i_in_we,
	input wire logic [8:0] i_in_addr,
	input wire logic [7:0] i_in_data,
	input wire logic [8:0] i_out_addr,
	output logic [7:0] o_out_data
);
	import mbm_pkg::*;

	typedef enum {ST_IDLE, ST_CHECK, ST_WRITE, ST_READ, ST_DONE} mbm_state_t;

	mbm_state_t state;
	mbm_req_t req;
	logic [7:0] mem [0:BUF_BYTES-1];
	logic [12:0] cur;
	logic [12:0] rd_bit;
	logic [12:0] step;
	logic [15:0] cnt;
	logic [7:0] exc;

	logic is_coil, is_write, is_multi, is_rw, is_single;
	logic supported, qty_ok, a_ok, b_ok, a_out, b_out;
	logic [15:0] qty_a;
	logic [20:0] a_m, a_e, b_m, b_e;
	logic [7:0] next_exc;
	logic take, last;
	logic [9:0] cur_byte;
	logic [15:0] cur_word, masked, wdata;
	logic cur_bit, wbit;

	// map position of an element address
	function automatic logic [20:0] map_pos(input logic [15:0] a,
		input logic coil, input logic strict, input logic out_area);
		logic [20:0] m;
		m = coil ? {5'h00, a} : {1'b0, a, 4'h0};
		if (strict && out_area) begin
			m = m + MAP_OUT_LO;
		end
		return m;
	endfunction : map_pos

	// map position to bit index in the buffer
	function automatic logic [12:0] buf_bit(input logic [20:0] m);
		logic [20:0] b;
		b = (m >= MAP_OUT_LO) ? (m - MAP_OUT_LO + BUF_OUT_BIT) : m;
		return b[12:0];
	endfunction : buf_bit

	// end of an element range, inclusive
	function automatic logic [20:0] map_end(input logic [20:0] m,
		input logic [15:0] q, input logic coil);
		logic [20:0] e;
		e = m + (coil ? {5'h00, q} : {1'b0, q, 4'h0}) - 21'h000001;
		return e;
	endfunction : map_end

	// range lies in input area or output area
	function automatic logic in_region(input logic [20:0] m,
		input logic [20:0] e, output logic out_area);
		out_area = (m >= MAP_OUT_LO);
		return (e < MAP_IN_END) || (out_area && e < MAP_OUT_END);
	endfunction : in_region

	always_comb begin
		is_coil = (req.fc == FC_RD_COILS) || (req.fc == FC_RD_DISC) ||
			(req.fc == FC_WR_COIL) || (req.fc == FC_WR_COILS);
		is_multi = (req.fc == FC_WR_COILS) || (req.fc == FC_WR_REGS) ||
			(req.fc == FC_RD_WR);
		is_single = (req.fc == FC_WR_COIL) || (req.fc == FC_WR_REG) ||
			(req.fc == FC_MASK_WR);
		is_rw = (req.fc == FC_RD_WR);
		is_write = is_single || (req.fc == FC_WR_COILS) ||
			(req.fc == FC_WR_REGS);
		qty_a = is_single ? QTY_ONE : req.qty;
		case (req.fc)
			FC_RD_HOLD, FC_RD_INPUT, FC_WR_REG, FC_WR_REGS,
			FC_MASK_WR, FC_RD_WR: supported = 1'b1;
			FC_RD_COILS, FC_RD_DISC, FC_WR_COIL,
			FC_WR_COILS: supported = !i_strict_mode;
			default: supported = 1'b0;
		endcase
		case (req.fc)
			FC_RD_COILS, FC_RD_DISC: qty_ok = (req.qty != 16'h0000) &&
				(req.qty <= QTY_BITS_MAX);
			FC_RD_HOLD, FC_RD_INPUT: qty_ok = (req.qty != 16'h0000) &&
				(req.qty <= QTY_RREG_MAX);
			FC_WR_COILS, FC_WR_REGS: qty_ok = (req.qty != 16'h0000) &&
				(req.qty <= QTY_WMULT_MAX);
			FC_RD_WR: qty_ok = (req.qty != 16'h0000) &&
				(req.qty <= QTY_RREG_MAX) && (req.wr_qty != 16'h0000) &&
				(req.wr_qty <= QTY_RW_WR_MAX);
			FC_WR_COIL: qty_ok = (req.value == COIL_ON) ||
				(req.value == COIL_OFF);
			default: qty_ok = 1'b1;
		endcase
		a_m = map_pos(req.addr, is_coil, i_strict_mode,
			req.fc != FC_RD_INPUT);
		a_e = map_end(a_m, qty_a, is_coil);
		b_m = map_pos(req.wr_addr, 1'b0, i_strict_mode, 1'b1);
		b_e = map_end(b_m, req.wr_qty, 1'b0);
		a_ok = in_region(a_m, a_e, a_out);
		b_ok = in_region(b_m, b_e, b_out);
		if (!supported) begin
			next_exc = EXC_FUNC;
		end else if (!qty_ok) begin
			next_exc = EXC_DATA;
		end else if (!a_ok || (is_write && !a_out) ||
			(is_rw && (!b_ok || !b_out)) ||
			(i_strict_mode && a_out &&
			(req.fc == FC_RD_INPUT))) begin
			next_exc = EXC_ADDR;
		end else begin
			next_exc = EXC_NONE;
		end
	end

	// current element access
	always_comb begin
		cur_byte = cur[12:3];
		cur_bit = mem[cur_byte][BIT_MSB - cur[2:0]];
		cur_word = {mem[cur_byte], mem[cur_byte + BYTE_NEXT]};
		masked = (cur_word & req.and_mask) | (req.or_mask & ~req.and_mask);
		if (req.fc == FC_MASK_WR) begin
			wdata = masked;
		end else if (is_multi) begin
			wdata = i_wr.data;
		end else begin
			wdata = req.value;
		end
		wbit = (req.fc == FC_WR_COIL) ? (req.value == COIL_ON) : wdata[0];
		take = (state == ST_WRITE) &&
			(!is_multi || (i_wr.valid && o_wr_ready));
		last = (cnt == QTY_ONE);
	end

	// request sequencing
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			state <= ST_IDLE;
			req <= '0;
			exc <= EXC_NONE;
			cur <= '0;
			rd_bit <= '0;
			step <= STEP_REG;
			cnt <= '0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (i_req.valid) begin
						req <= i_req;
						state <= ST_CHECK;
					end
				end
				ST_CHECK: begin
					exc <= next_exc;
					step <= is_coil ? STEP_COIL : STEP_REG;
					rd_bit <= buf_bit(a_m);
					if (next_exc != EXC_NONE) begin
						state <= ST_DONE;
					end else if (is_rw) begin
						cur <= buf_bit(b_m);
						cnt <= req.wr_qty;
						state <= ST_WRITE;
					end else begin
						cur <= buf_bit(a_m);
						cnt <= qty_a;
						state <= is_write ? ST_WRITE : ST_READ;
					end
				end
				ST_WRITE: begin
					if (take) begin
						cur <= cur + step;
						cnt <= cnt - QTY_ONE;
						if (last && is_rw) begin
							cur <= rd_bit;
							cnt <= req.qty;
							state <= ST_READ;
						end else if (last) begin
							state <= ST_DONE;
						end
					end
				end
				ST_READ: begin
					if (!o_rd.valid || i_rd_ready) begin
						if (cnt == 16'h0000) begin
							state <= ST_DONE;
						end else begin
							cur <= cur + step;
							cnt <= cnt - QTY_ONE;
						end
					end
				end
				ST_DONE: state <= ST_IDLE;
				default: state <= ST_IDLE;
			endcase
		end
	end

	// buffer storage, master writes and input-area fill
	always_ff @(posedge i_core_clk) begin
		if (take) begin
			if (step == STEP_COIL) begin
				mem[cur_byte][BIT_MSB - cur[2:0]] <= wbit;
			end else begin
				mem[cur_byte] <= wdata[15:8];
				mem[cur_byte + BYTE_NEXT] <= wdata[7:0];
			end
		end
		if (i_in_we) begin
			mem[{1'b0, i_in_addr}] <= i_in_data;
		end
	end

	// write data handshake
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_wr_ready <= 1'b0;
		end else if (state == ST_CHECK) begin
			o_wr_ready <= (next_exc == EXC_NONE) && is_multi;
		end else if (take && last) begin
			o_wr_ready <= 1'b0;
		end
	end

	// read data stream
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_rd <= '0;
		end else if (state == ST_READ && (!o_rd.valid || i_rd_ready)) begin
			o_rd.valid <= (cnt != 16'h0000);
			o_rd.data <= (step == STEP_COIL) ? {15'h0000, cur_bit} :
				cur_word;
		end else if (i_rd_ready) begin
			o_rd.valid <= 1'b0;
		end
	end

	// completion and ready
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_rsp <= '0;
			o_req_ready <= 1'b0;
		end else begin
			o_rsp.done <= (state == ST_DONE);
			o_rsp.exc <= (state == ST_DONE) ? exc : EXC_NONE;
			o_req_ready <= (state == ST_IDLE) && !i_req.valid;
		end
	end

	// output area view for the far side
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_out_data <= '0;
		end else begin
			o_out_data <= mem[{1'b1, i_out_addr}];
		end
	end
endmodule : mbm_mapper

// ===== hw/mbm_pkg.sv
// shared constants and carriers for the modbus i/o address mapper
package mbm_pkg;
	localparam logic [7:0] FC_RD_COILS = 8'h01;
	localparam logic [7:0] FC_RD_DISC = 8'h02;
	localparam logic [7:0] FC_RD_HOLD = 8'h03;
	localparam logic [7:0] FC_RD_INPUT = 8'h04;
	localparam logic [7:0] FC_WR_COIL = 8'h05;
	localparam logic [7:0] FC_WR_REG = 8'h06;
	localparam logic [7:0] FC_WR_COILS = 8'h0F;
	localparam logic [7:0] FC_WR_REGS = 8'h10;
	localparam logic [7:0] FC_MASK_WR = 8'h16;
	localparam logic [7:0] FC_RD_WR = 8'h17;
	localparam logic [7:0] EXC_NONE = 8'h00;
	localparam logic [7:0] EXC_FUNC = 8'h01;
	localparam logic [7:0] EXC_ADDR = 8'h02;
	localparam logic [7:0] EXC_DATA = 8'h03;
	localparam logic [15:0] COIL_ON = 16'hFF00;
	localparam logic [15:0] COIL_OFF = 16'h0000;
	localparam logic [15:0] QTY_ONE = 16'h0001;
	localparam logic [15:0] QTY_BITS_MAX = 16'h07D0;
	localparam logic [15:0] QTY_RREG_MAX = 16'h007D;
	localparam logic [15:0] QTY_WMULT_MAX = 16'h0320;
	localparam logic [15:0] QTY_RW_WR_MAX = 16'h0064;
	// map positions in bits; one register spans 16 map bits
	localparam int MAP_W = 21;
	localparam logic [20:0] MAP_IN_END = 21'h001000;
	localparam logic [20:0] MAP_OUT_LO = 21'h004000;
	localparam logic [20:0] MAP_OUT_END = 21'h005000;
	localparam logic [20:0] BUF_OUT_BIT = 21'h001000;
	localparam int BUF_BYTES = 1024;
	localparam logic [12:0] STEP_COIL = 13'h0001;
	localparam logic [12:0] STEP_REG = 13'h0010;
	localparam logic [2:0] BIT_MSB = 3'h7;
	localparam logic [9:0] BYTE_NEXT = 10'h001;

	typedef struct packed {
		logic valid;
		logic [7:0] fc;
		logic [15:0] addr;
		logic [15:0] qty;
		logic [15:0] wr_addr;
		logic [15:0] wr_qty;
		logic [15:0] value;
		logic [15:0] and_mask;
		logic [15:0] or_mask;
	} mbm_req_t;

	typedef struct packed {
		logic done;
		logic [7:0] exc;
	} mbm_rsp_t;

	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} mbm_word_t;
endpackage : mbm_pkg

// ===== test/mbm_checker.sv
// port assertions for the mapper
`timescale 1ns/100ps
module mbm_checker import mbm_pkg::*; (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_strict_mode,
	input wire mbm_pkg::mbm_req_t i_req,
	input wire logic o_req_ready,
	input wire logic o_wr_ready,
	input wire mbm_pkg::mbm_word_t o_rd,
	input wire logic i_rd_ready,
	input wire mbm_pkg::mbm_rsp_t o_rsp
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	logic tk;
	assign tk = o_req_ready && i_req.valid;
	sequence s_exc(logic [7:0] e);
		##3 o_rsp.done && o_rsp.exc == e;
	endsequence
	property p_func;
		tk && i_req.fc == 8'h07 |-> s_exc(EXC_FUNC);
	endproperty
	a_func: assert property (p_func) else $error("bad code not refused");
	property p_coil_strict;
		tk && i_strict_mode && i_req.fc == FC_RD_COILS |-> s_exc(EXC_FUNC);
	endproperty
	a_coil_strict: assert property (p_coil_strict) else $error("coil taken");
	property p_bits;
		tk && !i_strict_mode && i_req.fc == FC_RD_COILS
			&& i_req.qty > QTY_BITS_MAX |-> s_exc(EXC_DATA);
	endproperty
	a_bits: assert property (p_bits) else $error("bit count taken");
	property p_rw;
		tk && i_req.fc == FC_RD_WR && i_req.wr_qty > QTY_RW_WR_MAX
			|-> s_exc(EXC_DATA);
	endproperty
	a_rw: assert property (p_rw) else $error("rw count taken");
	property p_resv;
		tk && !i_strict_mode && i_req.fc == FC_RD_HOLD && i_req.qty == QTY_ONE
			&& i_req.addr inside {[16'h0100:16'h03FF]} |-> s_exc(EXC_ADDR);
	endproperty
	a_resv: assert property (p_resv) else $error("reserved read");
	property p_wr_in;
		tk && !i_strict_mode && i_req.fc == FC_WR_REG && i_req.addr < 16'h0100
			|-> s_exc(EXC_ADDR);
	endproperty
	a_wr_in: assert property (p_wr_in) else $error("input written");
	property p_strict_in;
		tk && i_strict_mode && i_req.fc == FC_RD_INPUT && i_req.qty == QTY_ONE
			&& i_req.addr >= 16'h0100 |-> s_exc(EXC_ADDR);
	endproperty
	a_strict_in: assert property (p_strict_in) else $error("input range");
	property p_pulse;
		o_rsp.done |=> !o_rsp.done;
	endproperty
	a_pulse: assert property (p_pulse) else $error("done too long");
	property p_hold;
		o_rd.valid && !i_rd_ready |=> o_rd.valid && $stable(o_rd.data);
	endproperty
	a_hold: assert property (p_hold) else $error("read word lost");
	property p_taken;
		tk |=> !o_req_ready;
	endproperty
	a_taken: assert property (p_taken) else $error("ready kept");
	property p_wr_close;
		o_rsp.done |-> !o_wr_ready;
	endproperty
	a_wr_close: assert property (p_wr_close) else $error("write port open");
	c_rw: cover property (tk && i_req.fc == FC_RD_WR);
	c_ok: cover property (o_rsp.done && o_rsp.exc == EXC_NONE);
	c_stall: cover property (o_rd.valid && !i_rd_ready);
endmodule : mbm_checker

// ===== test/mbm_master.sv
// remote master model: requests, write words, read capture
`timescale 1ns/100ps
module mbm_master import mbm_pkg::*; (
	input wire logic i_core_clk,
	output mbm_pkg::mbm_req_t o_req,
	input wire logic i_req_ready,
	output mbm_pkg::mbm_word_t o_wr,
	input wire logic i_wr_ready,
	input wire mbm_pkg::mbm_word_t i_rd,
	output logic o_rd_ready,
	input wire mbm_pkg::mbm_rsp_t i_rsp
);
	logic [15:0] wq[$];
	logic [15:0] rdq[$];
	logic slow = 1'b0;
	initial o_req = '0;
	initial o_wr = '0;
	initial o_rd_ready = 1'b1;
	always @(negedge i_core_clk) begin
		o_wr.valid <= wq.size() != 0;
		o_wr.data <= wq.size() != 0 ? wq[0] : ~o_wr.data;
		o_rd_ready <= slow ? ~o_rd_ready : 1'b1;
	end
	always @(posedge i_core_clk) begin
		if (o_wr.valid && i_wr_ready)
			void'(wq.pop_front());
		if (i_rd.valid && o_rd_ready)
			rdq.push_back(i_rd.data);
	end
	task run(input mbm_req_t r, output logic [7:0] e);
		rdq = {};
		while (i_req_ready !== 1'b1)
			@(negedge i_core_clk);
		o_req <= r;
		@(negedge i_core_clk);
		o_req.valid <= 1'b0;
		while (i_rsp.done !== 1'b1)
			@(negedge i_core_clk);
		e = i_rsp.exc;
		@(negedge i_core_clk);
	endtask : run
endmodule : mbm_master

// ===== test/tb_top.sv
// self-checking bench for the mapper
`timescale 1ns/100ps
module tb_top;
	import mbm_pkg::*;
	logic i_core_clk = 0, i_rst = 1, strict = 0, we = 0, req_rdy, wr_rdy, rd_rdy;
	logic [8:0] in_a = 0, out_a = 0;
	logic [7:0] in_d = 0, out_d, exc;
	logic [15:0] wn = 16'h0001;
	mbm_req_t req;
	mbm_word_t wr, rd;
	mbm_rsp_t rsp;
	int fails = 0, n_checks = 0, cyc = 0;
	always #5 i_core_clk = ~i_core_clk;
	mbm_mapper i_mbm_mapper(.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_strict_mode(strict), .i_req(req), .o_req_ready(req_rdy), .i_wr(wr),
		.o_wr_ready(wr_rdy), .o_rd(rd), .i_rd_ready(rd_rdy), .o_rsp(rsp),
		.i_in_we(we), .i_in_addr(in_a), .i_in_data(in_d), .i_out_addr(out_a),
		.o_out_data(out_d));
	mbm_master i_mbm_master(.i_core_clk(i_core_clk), .o_req(req),
		.i_req_ready(req_rdy), .o_wr(wr), .i_wr_ready(wr_rdy), .i_rd(rd),
		.o_rd_ready(rd_rdy), .i_rsp(rsp));
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task go(input logic [7:0] f, input logic [15:0] a, q, v);
		mbm_req_t r;
		r = '0;
		r.valid = 1'b1;
		r.fc = f;
		r.addr = a;
		r.qty = q;
		r.value = v;
		r.wr_addr = a;
		r.wr_qty = wn;
		r.and_mask = 16'h00FF;
		r.or_mask = 16'hAB00;
		i_mbm_master.run(r, exc);
	endtask : go
	task inb(input logic [8:0] a, input logic [7:0] d);
		we = 1;
		in_a = a;
		in_d = d;
		@(negedge i_core_clk);
		we = 0;
		@(negedge i_core_clk);
	endtask : inb
	task ob(input logic [8:0] a, input logic [15:0] e);
		out_a = a;
		@(negedge i_core_clk);
		chk("out", e, {8'h00, out_d});
	endtask : ob
	task t_strict;
		strict = 1;
		inb(9'h1FE, 8'hA5);
		inb(9'h1FF, 8'h3C);
		go(FC_RD_INPUT, 16'h00FF, QTY_ONE, 16'h0000);
		chk("rd", 16'hA53C, i_mbm_master.rdq[0]);
		go(FC_RD_INPUT, 16'h0100, QTY_ONE, 16'h0000);
		chk("exc", EXC_ADDR, {8'h00, exc});
		go(FC_RD_INPUT, 16'h0400, QTY_ONE, 16'h0000);
		chk("exc", EXC_ADDR, {8'h00, exc});
		go(FC_WR_REG, 16'h00FF, QTY_ONE, 16'h1234);
		ob(9'h1FE, 16'h0012);
		ob(9'h1FF, 16'h0034);
		go(FC_MASK_WR, 16'h00FF, QTY_ONE, 16'h0000);
		go(FC_RD_HOLD, 16'h00FF, QTY_ONE, 16'h0000);
		chk("rd", 16'hAB34, i_mbm_master.rdq[0]);
		go(FC_RD_COILS, 16'h0000, QTY_ONE, 16'h0000);
		chk("exc", EXC_FUNC, {8'h00, exc});
		$display("strict test done");
	endtask : t_strict
	task t_flex;
		strict = 0;
		i_mbm_master.wq = {16'h0011, 16'h2233};
		go(FC_WR_REGS, 16'h0400, 16'h0002, 16'h0000);
		ob(9'h000, 16'h0000);
		ob(9'h003, 16'h0033);
		go(FC_WR_COIL, 16'h4000, QTY_ONE, COIL_ON);
		ob(9'h000, 16'h0080);
		i_mbm_master.wq = {16'h0000};
		go(FC_WR_COILS, 16'h4000, QTY_ONE, 16'h0000);
		ob(9'h000, 16'h0000);
		go(FC_RD_HOLD, 16'h04FF, QTY_ONE, 16'h0000);
		chk("rd", 16'hAB34, i_mbm_master.rdq[0]);
		i_mbm_master.slow = 1;
		go(FC_RD_COILS, 16'h0FF0, 16'h0002, 16'h0000);
		chk("coil", 16'h0001, i_mbm_master.rdq[0] & 16'h0001);
		chk("coil", 16'h0000, i_mbm_master.rdq[1] & 16'h0001);
		i_mbm_master.slow = 0;
		go(FC_RD_DISC, 16'h0FF0, QTY_ONE, 16'h0000);
		chk("coil", 16'h0001, i_mbm_master.rdq[0] & 16'h0001);
		go(FC_RD_HOLD, 16'h0000, QTY_RREG_MAX, 16'h0000);
		chk("n", 16'h007D, 16'(i_mbm_master.rdq.size()));
		i_mbm_master.wq = {16'hBEEF};
		go(FC_RD_WR, 16'h0401, QTY_ONE, 16'h0000);
		chk("rd", 16'hBEEF, i_mbm_master.rdq[0]);
		go(FC_RD_HOLD, 16'h012C, QTY_ONE, 16'h0000);
		chk("exc", EXC_ADDR, {8'h00, exc});
		go(FC_WR_REG, 16'h0000, QTY_ONE, 16'h5555);
		chk("exc", EXC_ADDR, {8'h00, exc});
		go(FC_RD_HOLD, 16'h0500, QTY_ONE, 16'h0000);
		chk("exc", EXC_ADDR, {8'h00, exc});
		go(FC_RD_HOLD, 16'h0000, 16'h007E, 16'h0000);
		chk("exc", EXC_DATA, {8'h00, exc});
		go(FC_RD_COILS, 16'h0000, 16'h07D1, 16'h0000);
		chk("exc", EXC_DATA, {8'h00, exc});
		wn = 16'h0065;
		go(FC_RD_WR, 16'h0400, QTY_ONE, 16'h0000);
		chk("exc", EXC_DATA, {8'h00, exc});
		go(8'h07, 16'h0000, QTY_ONE, 16'h0000);
		chk("exc", EXC_FUNC, {8'h00, exc});
		$display("flexible test done");
	endtask : t_flex
	task stop_test;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test
	always @(posedge i_core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			stop_test;
		end
	end
	initial begin
		repeat (8) @(negedge i_core_clk);
		i_rst = 0;
		@(negedge i_core_clk);
		t_strict;
		t_flex;
		stop_test;
	end
endmodule : tb_top
bind mbm_mapper mbm_checker i_mbm_checker(.i_core_clk(i_core_clk),
	.i_rst(i_rst), .i_strict_mode(i_strict_mode), .i_req(i_req),
	.o_req_ready(o_req_ready), .o_wr_ready(o_wr_ready),
	.o_rd(o_rd), .i_rd_ready(i_rd_ready),
	.o_rsp(o_rsp));
